// ==== rtl/crpv_defines.vh ====
`ifndef CRPV_DEFINES_VH
`define CRPV_DEFINES_VH

// ****************************************************************
// Reset values
// ****************************************************************
`define CRPV_SP_RESET 16'h0800
`define CRPV_CC_RESET 16'h0000

// ****************************************************************
// Register word indexes, byte address is four times the index
// ****************************************************************
`define CRPV_IDX_ACC0_L 5'h10
`define CRPV_IDX_ACC0_H 5'h11
`define CRPV_IDX_ACC0_U 5'h12
`define CRPV_IDX_ACC1_L 5'h13
`define CRPV_IDX_ACC1_H 5'h14
`define CRPV_IDX_ACC1_U 5'h15
`define CRPV_IDX_FLAGS 5'h16
`define CRPV_IDX_CORE_CTRL 5'h17
`define CRPV_IDX_TBL_PAGE 5'h18
`define CRPV_IDX_VIS_PAGE 5'h19
`define CRPV_IDX_LOOP_BEGIN 5'h1A
`define CRPV_IDX_LOOP_FINISH 5'h1B
`define CRPV_IDX_LOOP_COUNT 5'h1C
`define CRPV_IDX_REPEAT_COUNT 5'h1D
`define CRPV_IDX_PC_LOW 5'h1E
`define CRPV_IDX_PC_HIGH 5'h1F

// ****************************************************************
// Field positions
// ****************************************************************
`define CRPV_FLG_CARRY 0
`define CRPV_FLG_ZERO 1
`define CRPV_FLG_OVF 2
`define CRPV_FLG_NEG 3
`define CRPV_FLG_REP 4
`define CRPV_FLG_PRIO_LO 5
`define CRPV_FLG_PRIO_HI 7
`define CRPV_FLG_DIGC 8
`define CRPV_FLG_LOOP 9
`define CRPV_CC_VIS 2
`define CRPV_EA_MSB 15
`define CRPV_VIS_LOW_BITS 15

// ****************************************************************
// Visibility stall counts, in instruction cycles
// ****************************************************************
`define CRPV_EXTRA_NONE 2'h0
`define CRPV_EXTRA_ONE 2'h1
`define CRPV_EXTRA_TWO 2'h2

`endif

// ==== rtl/crpv_wreg_file.v ====
`timescale 1ns/1ps

// ****************************************************************
// Working register array with save/restore shadows
// ****************************************************************
module crpv_wreg_file #(
   parameter WIDTH = 16,
   parameter DEPTH = 16,
   parameter AW = 4,
   parameter SHADOW_N = 4,
   parameter [15:0] SP_RESET = 16'h0800
) (
   input wire clock,
   input wire resetn,
   input wire wr_en,
   input wire [AW-1:0] wr_addr,
   input wire [1:0] wr_be,
   input wire [WIDTH-1:0] wr_data,
   input wire shadow_save,
   input wire shadow_restore,
   input wire sp_inc,
   input wire sp_dec,
   input wire link_op,
   input wire [WIDTH-1:0] link_size,
   input wire unlink_op,
   input wire [WIDTH-1:0] unlink_fp,
   input wire [AW-1:0] rd_addr_a,
   output reg [WIDTH-1:0] rd_data_a,
   input wire [AW-1:0] rd_addr_b,
   output reg [WIDTH-1:0] rd_data_b,
   output wire [WIDTH-1:0] sp_value
);

   wire [WIDTH*DEPTH-1:0] flat;
   wire [WIDTH-1:0] sp_q;
   wire [WIDTH-1:0] fp_q;

   assign sp_q = flat[(DEPTH-1)*WIDTH +: WIDTH];
   assign fp_q = flat[(DEPTH-2)*WIDTH +: WIDTH];
   assign sp_value = sp_q;

   // One entry per register; a direct write beats a pointer update
   genvar i;
   generate
      for (i = 0; i < DEPTH; i = i + 1)
      begin : g_ent
         localparam [AW-1:0] IDX = i;
         localparam [WIDTH-1:0] RST = (i == DEPTH-1) ? SP_RESET : {WIDTH{1'b0}};
         reg [WIDTH-1:0] q;
         reg [WIDTH-1:0] sh;
         reg [WIDTH-1:0] next_q;
         always @*
         begin
            next_q = q;
            if (wr_en && wr_addr == IDX)
            begin
               if (wr_be[0])
                  next_q[7:0] = wr_data[7:0];
               if (wr_be[1])
                  next_q[WIDTH-1:8] = wr_data[WIDTH-1:8];
            end
            else if (i == DEPTH-1)
            begin
               if (link_op)
                  next_q = sp_q + link_size;
               else if (unlink_op)
                  next_q = fp_q;
               else if (sp_inc)
                  next_q = sp_q + 16'h0002;
               else if (sp_dec)
                  next_q = sp_q - 16'h0002;
            end
            else if (i == DEPTH-2)
            begin
               if (link_op)
                  next_q = sp_q;
               else if (unlink_op)
                  next_q = unlink_fp;
            end
            if (shadow_restore && i < SHADOW_N)
               next_q = sh;
            if (i == DEPTH-1)
               next_q[0] = 1'b0;
         end
         // Shadows only move on save events
         always @(posedge clock)
         begin
            if (!resetn)
            begin
               q <= RST;
               sh <= {WIDTH{1'b0}};
            end
            else
            begin
               q <= next_q;
               if (shadow_save && i < SHADOW_N)
                  sh <= q;
            end
         end
         assign flat[i*WIDTH +: WIDTH] = q;
      end
   endgenerate

   // Registered read ports, one for the bus and one for execution
   always @(posedge clock)
   begin
      if (!resetn)
      begin
         rd_data_a <= {WIDTH{1'b0}};
         rd_data_b <= {WIDTH{1'b0}};
      end
      else
      begin
         rd_data_a <= flat[rd_addr_a*WIDTH +: WIDTH];
         rd_data_b <= flat[rd_addr_b*WIDTH +: WIDTH];
      end
   end

endmodule // crpv_wreg_file

// ==== rtl/crpv_core_regs.v ====
`timescale 1ns/1ps
`include "crpv_defines.vh"

module crpv_core_regs (
   input wire clock,
   input wire resetn,
   input wire [4:0] avs_address,
   input wire avs_read,
   input wire avs_write,
   input wire [3:0] avs_byteenable,
   input wire [31:0] avs_writedata,
   output reg [31:0] avs_readdata,
   output reg avs_waitrequest,
   input wire exe_wr_en,
   input wire [3:0] exe_wr_idx,
   input wire [15:0] exe_wr_data,
   input wire exe_wr_byte,
   input wire [3:0] exe_rd_idx,
   output wire [15:0] exe_rd_data,
   output wire [15:0] stack_pointer,
   input wire shadow_push,
   input wire shadow_pop,
   input wire sp_push,
   input wire sp_pop,
   input wire frame_link_op,
   input wire [15:0] frame_size,
   input wire frame_unlink_op,
   input wire [15:0] frame_restore,
   input wire [1:0] acc_we,
   input wire [39:0] acc_wdata,
   output reg [39:0] accum_a,
   output reg [39:0] accum_b,
   input wire [15:0] flags_wmask,
   input wire [15:0] flags_wdata,
   output reg [15:0] cpu_flags_reg,
   input wire loop_enter,
   input wire loop_exit,
   input wire [15:0] loop_begin_in,
   input wire [15:0] loop_finish_in,
   input wire [15:0] loop_count_in,
   input wire exc_entry,
   output reg [15:0] exc_stack_word,
   input wire pc_step,
   input wire pc_load,
   input wire [22:0] pc_load_value,
   output reg [22:0] program_counter,
   input wire data_ea_valid,
   input wire [15:0] data_ea,
   input wire table_active,
   input wire [15:0] table_ea,
   input wire insn_short_vis,
   input wire in_repeat,
   input wire repeat_edge,
   input wire [23:0] prog_word,
   output reg [23:0] prog_addr,
   output reg vis_hit,
   output reg [1:0] vis_extra,
   output reg [15:0] vis_rdata
);

   // ****************************************************************
   // Programmer-visible state
   // ****************************************************************
   reg [15:0] core_ctrl_reg;
   reg [7:0] table_page_reg;
   reg [7:0] visibility_page_reg;
   reg [15:0] loop_begin_reg;
   reg [15:0] loop_finish_reg;
   reg [15:0] loop_iter_count;
   reg [15:0] repeat_iter_count;
   reg [15:0] loop_begin_sh;
   reg [15:0] loop_finish_sh;
   reg [15:0] loop_iter_sh;
   reg [4:0] flags_sh;
   reg pend;
   reg [15:0] bus_rdata;
   reg [1:0] next_extra;

   wire [15:0] bus_rd_w;
   wire w_target;
   wire bus_stall;
   wire bus_done;
   wire bus_wr;
   wire [15:0] wdat;
   wire [1:0] wbe;
   wire mem_wr_en;
   wire [3:0] mem_wr_addr;
   wire [1:0] mem_wr_be;
   wire [15:0] mem_wr_data;
   wire prog_visibility_enable;
   wire vis_sel;

   // Byte-lane merge for bus writes to 16-bit registers
   function [15:0] merge16;
      input [15:0] old;
      input [15:0] din;
      input [1:0] be;
      begin
         merge16 = old;
         if (be[0])
            merge16[7:0] = din[7:0];
         if (be[1])
            merge16[15:8] = din[15:8];
      end
   endfunction

   // ****************************************************************
   // Avalon slave handshake
   // ****************************************************************
   // Working registers share one write port; execution wins and the bus
   // waits, so an execution write never drops a bus write; a same-cycle shadow restore still overrides one to registers 0-3.
   assign w_target = ~avs_address[4];
   assign bus_stall = avs_write & w_target & exe_wr_en;
   assign bus_done = pend & ~bus_stall;
   assign bus_wr = bus_done & avs_write;
   assign wdat = avs_writedata[15:0];
   assign wbe = avs_byteenable[1:0];

   always @(posedge clock)
   begin
      if (!resetn)
      begin
         pend <= 1'b0;
         avs_waitrequest <= 1'b1;
         avs_readdata <= 32'h00000000;
      end
      else
      begin
         if (!avs_waitrequest)
            avs_waitrequest <= 1'b1;
         if (!pend && avs_waitrequest && (avs_read || avs_write))
            pend <= 1'b1;
         else if (bus_done)
         begin
            pend <= 1'b0;
            avs_waitrequest <= 1'b0;
            if (avs_read)
               avs_readdata <= {16'h0000, bus_rdata};
         end
      end
   end

   // Read mux; shadows have no address at all
   always @*
   begin
      case (avs_address)
         `CRPV_IDX_ACC0_L: bus_rdata = accum_a[15:0];
         `CRPV_IDX_ACC0_H: bus_rdata = accum_a[31:16];
         `CRPV_IDX_ACC0_U: bus_rdata = {8'h00, accum_a[39:32]};
         `CRPV_IDX_ACC1_L: bus_rdata = accum_b[15:0];
         `CRPV_IDX_ACC1_H: bus_rdata = accum_b[31:16];
         `CRPV_IDX_ACC1_U: bus_rdata = {8'h00, accum_b[39:32]};
         `CRPV_IDX_FLAGS: bus_rdata = cpu_flags_reg;
         `CRPV_IDX_CORE_CTRL: bus_rdata = core_ctrl_reg;
         `CRPV_IDX_TBL_PAGE: bus_rdata = {8'h00, table_page_reg};
         `CRPV_IDX_VIS_PAGE: bus_rdata = {8'h00, visibility_page_reg};
         `CRPV_IDX_LOOP_BEGIN: bus_rdata = loop_begin_reg;
         `CRPV_IDX_LOOP_FINISH: bus_rdata = loop_finish_reg;
         `CRPV_IDX_LOOP_COUNT: bus_rdata = loop_iter_count;
         `CRPV_IDX_REPEAT_COUNT: bus_rdata = repeat_iter_count;
         `CRPV_IDX_PC_LOW: bus_rdata = program_counter[15:0];
         `CRPV_IDX_PC_HIGH: bus_rdata = {9'h000, program_counter[22:16]};
         default: bus_rdata = bus_rd_w;
      endcase
   end

   // ****************************************************************
   // Working registers
   // ****************************************************************
   // A byte op from execution writes the low lane only
   assign mem_wr_en = exe_wr_en | (bus_wr & w_target);
   assign mem_wr_addr = exe_wr_en ? exe_wr_idx : avs_address[3:0];
   assign mem_wr_be = exe_wr_en ? {~exe_wr_byte, 1'b1} : wbe;
   assign mem_wr_data = exe_wr_en ? exe_wr_data : wdat;

   crpv_wreg_file #(
      .WIDTH(16),
      .DEPTH(16),
      .AW(4),
      .SHADOW_N(4),
      .SP_RESET(`CRPV_SP_RESET)
   ) u_wregs (
      .clock(clock),
      .resetn(resetn),
      .wr_en(mem_wr_en),
      .wr_addr(mem_wr_addr),
      .wr_be(mem_wr_be),
      .wr_data(mem_wr_data),
      .shadow_save(shadow_push),
      .shadow_restore(shadow_pop),
      .sp_inc(sp_push | exc_entry),
      .sp_dec(sp_pop),
      .link_op(frame_link_op),
      .link_size(frame_size),
      .unlink_op(frame_unlink_op),
      .unlink_fp(frame_restore),
      .rd_addr_a(avs_address[3:0]),
      .rd_data_a(bus_rd_w),
      .rd_addr_b(exe_rd_idx),
      .rd_data_b(exe_rd_data),
      .sp_value(stack_pointer)
   );

   // ****************************************************************
   // Accumulators, flags and control
   // ****************************************************************
   // Software writes land last, so they win over same-cycle core updates
   always @(posedge clock)
   begin
      if (!resetn)
      begin
         accum_a <= 40'h0000000000;
         accum_b <= 40'h0000000000;
         cpu_flags_reg <= 16'h0000;
         flags_sh <= 5'h00;
         core_ctrl_reg <= `CRPV_CC_RESET;
         table_page_reg <= 8'h00;
         visibility_page_reg <= 8'h00;
         repeat_iter_count <= 16'h0000;
         exc_stack_word <= 16'h0000;
      end
      else
      begin
         if (acc_we[0])
            accum_a <= acc_wdata;
         if (acc_we[1])
            accum_b <= acc_wdata;
         cpu_flags_reg <= (cpu_flags_reg & ~flags_wmask) | (flags_wdata & flags_wmask);
         if (shadow_push)
            flags_sh <= {cpu_flags_reg[`CRPV_FLG_DIGC],
                         cpu_flags_reg[`CRPV_FLG_NEG:`CRPV_FLG_CARRY]};
         if (shadow_pop)
         begin
            cpu_flags_reg[`CRPV_FLG_DIGC] <= flags_sh[4];
            cpu_flags_reg[`CRPV_FLG_NEG:`CRPV_FLG_CARRY] <= flags_sh[3:0];
         end
         // Low flag byte joined with the top counter byte for stacking
         if (exc_entry)
            exc_stack_word <= {cpu_flags_reg[7:0], 1'b0, program_counter[22:16]};
         if (bus_wr)
         begin
            case (avs_address)
               `CRPV_IDX_ACC0_L: accum_a[15:0] <= merge16(accum_a[15:0], wdat, wbe);
               `CRPV_IDX_ACC0_H: accum_a[31:16] <= merge16(accum_a[31:16], wdat, wbe);
               `CRPV_IDX_ACC0_U: if (wbe[0]) accum_a[39:32] <= wdat[7:0];
               `CRPV_IDX_ACC1_L: accum_b[15:0] <= merge16(accum_b[15:0], wdat, wbe);
               `CRPV_IDX_ACC1_H: accum_b[31:16] <= merge16(accum_b[31:16], wdat, wbe);
               `CRPV_IDX_ACC1_U: if (wbe[0]) accum_b[39:32] <= wdat[7:0];
               `CRPV_IDX_FLAGS: cpu_flags_reg <= merge16(cpu_flags_reg, wdat, wbe);
               `CRPV_IDX_CORE_CTRL: core_ctrl_reg <= merge16(core_ctrl_reg, wdat, wbe);
               `CRPV_IDX_TBL_PAGE: if (wbe[0]) table_page_reg <= wdat[7:0];
               `CRPV_IDX_VIS_PAGE: if (wbe[0]) visibility_page_reg <= wdat[7:0];
               `CRPV_IDX_REPEAT_COUNT:
                  repeat_iter_count <= merge16(repeat_iter_count, wdat, wbe);
               default: ;
            endcase
         end
      end
   end

   // ****************************************************************
   // Loop registers and their shadows
   // ****************************************************************
   always @(posedge clock)
   begin
      if (!resetn)
      begin
         loop_begin_reg <= 16'h0000;
         loop_finish_reg <= 16'h0000;
         loop_iter_count <= 16'h0000;
         loop_begin_sh <= 16'h0000;
         loop_finish_sh <= 16'h0000;
         loop_iter_sh <= 16'h0000;
      end
      else
      begin
         if (loop_enter)
         begin
            loop_begin_sh <= loop_begin_reg;
            loop_finish_sh <= loop_finish_reg;
            loop_iter_sh <= loop_iter_count;
            loop_begin_reg <= loop_begin_in;
            loop_finish_reg <= loop_finish_in;
            loop_iter_count <= loop_count_in;
         end
         else if (loop_exit)
         begin
            loop_begin_reg <= loop_begin_sh;
            loop_finish_reg <= loop_finish_sh;
            loop_iter_count <= loop_iter_sh;
         end
         if (bus_wr)
         begin
            case (avs_address)
               `CRPV_IDX_LOOP_BEGIN:
                  loop_begin_reg <= merge16(loop_begin_reg, wdat, wbe);
               `CRPV_IDX_LOOP_FINISH:
                  loop_finish_reg <= merge16(loop_finish_reg, wdat, wbe);
               `CRPV_IDX_LOOP_COUNT:
                  loop_iter_count <= merge16(loop_iter_count, wdat, wbe);
               default: ;
            endcase
         end
      end
   end

   // ****************************************************************
   // Program counter
   // ****************************************************************
   // Bit zero is forced on loads and low writes, and steps and high writes keep it, so it can never be set
   always @(posedge clock)
   begin
      if (!resetn)
         program_counter <= 23'h000000;
      else if (bus_wr && avs_address == `CRPV_IDX_PC_LOW)
         program_counter[15:0] <= merge16(program_counter[15:0], wdat, wbe) & 16'hFFFE;
      else if (bus_wr && avs_address == `CRPV_IDX_PC_HIGH)
      begin
         if (wbe[0])
            program_counter[22:16] <= wdat[6:0];
      end
      else if (pc_load)
         program_counter <= {pc_load_value[22:1], 1'b0};
      else if (pc_step)
         program_counter <= program_counter + 23'h000002;
   end

   // ****************************************************************
   // Program space visibility and address mapping
   // ****************************************************************
   assign prog_visibility_enable = core_ctrl_reg[`CRPV_CC_VIS];
   assign vis_sel = data_ea_valid & data_ea[`CRPV_EA_MSB] & prog_visibility_enable
                    & ~table_active;

   // Stall cost of a redirected access
   always @*
   begin
      if (!vis_sel)
         next_extra = `CRPV_EXTRA_NONE;
      else if (in_repeat)
         next_extra = repeat_edge ? `CRPV_EXTRA_TWO : `CRPV_EXTRA_NONE;
      else
         next_extra = insn_short_vis ? `CRPV_EXTRA_ONE : `CRPV_EXTRA_TWO;
   end

   // Only table accesses may set bit 23 and reach configuration space
   always @(posedge clock)
   begin
      if (!resetn)
      begin
         prog_addr <= 24'h000000;
         vis_hit <= 1'b0;
         vis_extra <= `CRPV_EXTRA_NONE;
         vis_rdata <= 16'h0000;
      end
      else
      begin
         vis_hit <= vis_sel;
         vis_extra <= next_extra;
         vis_rdata <= prog_word[15:0];
         if (vis_sel)
            prog_addr <= {1'b0, visibility_page_reg,
                          data_ea[`CRPV_VIS_LOW_BITS-1:0]};
         else if (table_active)
            prog_addr <= {table_page_reg, table_ea};
         else
            prog_addr <= {1'b0, program_counter};
      end
   end

endmodule // crpv_core_regs

// ==== tb/crpv_prog_mem.sv ====
`timescale 1ns/1ps
// Program memory behind the visibility window, answers at once
module crpv_prog_mem (
   input logic [23:0] prog_addr,
   output logic [23:0] prog_word
);
   // Top byte differs from the data half so a wrong slice shows
   assign prog_word = {prog_addr[7:0] ^ 8'h5A, prog_addr[15:0] ^ 16'hC3A5};
endmodule // crpv_prog_mem

// ==== tb/crpv_core_regs_asserts.sv ====
`timescale 1ns/1ps
// ********
// Core register checker
// ********
module crpv_core_regs_asserts (
   input logic clock,
   input logic resetn,
   input logic [15:0] stack_pointer,
   input logic pc_step,
   input logic pc_load,
   input logic [22:0] program_counter,
   input logic exc_entry,
   input logic [15:0] cpu_flags_reg,
   input logic [15:0] exc_stack_word,
   input logic table_active,
   input logic [15:0] data_ea,
   input logic [23:0] prog_word,
   input logic [23:0] prog_addr,
   input logic vis_hit,
   input logic [1:0] vis_extra,
   input logic [15:0] vis_rdata,
   input logic in_repeat,
   input logic repeat_edge,
   input logic insn_short_vis
);
   // All checks sample on the core clock and rest during reset, except the stack pointer reset check
   default clocking @(posedge clock); endclocking
   default disable iff (!resetn);
   chk_sp_align: assert property (stack_pointer[0] == 1'h0)
      else $error("stack pointer odd");
   chk_sp_reset: assert property (disable iff (1'h0) !resetn |=> stack_pointer == 16'h0800)
      else $error("stack pointer reset value");
   chk_pc_align: assert property (program_counter[0] == 1'h0)
      else $error("program counter odd");
   chk_pc_step: assert property (pc_step && !pc_load |=>
      program_counter == $past(program_counter) + 23'h000002) else $error("pc step");
   chk_exc_word: assert property (exc_entry |=> exc_stack_word ==
      {$past(cpu_flags_reg[7:0]), 1'h0, $past(program_counter[22:16])}) else $error("stacked word");
   chk_table_off: assert property (table_active |=> !vis_hit)
      else $error("redirect during table access");
   chk_vis_addr: assert property (vis_hit |-> !prog_addr[23] &&
      prog_addr[14:0] == $past(data_ea[14:0])) else $error("redirect address");
   chk_vis_data: assert property (vis_hit |-> vis_rdata == $past(prog_word[15:0]))
      else $error("redirect data");
   chk_vis_extra: assert property (vis_hit |-> vis_extra == ($past(in_repeat) ?
      ($past(repeat_edge) ? 2'h2 : 2'h0) : ($past(insn_short_vis) ? 2'h1 : 2'h2)))
      else $error("stall count");
endmodule // crpv_core_regs_asserts

bind crpv_core_regs crpv_core_regs_asserts u_crpv_core_regs_asserts (.*);

// ==== tb/crpv_core_regs_test.sv ====
`timescale 1ns/1ps
// ********
// Core register bench
// ********
module crpv_core_regs_test;
   logic clock, resetn, avs_read, avs_write, avs_waitrequest, exe_wr_en, exe_wr_byte, sp_pop;
   logic shadow_push, shadow_pop, sp_push, frame_link_op, frame_unlink_op, loop_enter;
   logic loop_exit, exc_entry, pc_step, pc_load, data_ea_valid, table_active, insn_short_vis;
   logic in_repeat, repeat_edge, vis_hit;
   logic [1:0] acc_we, vis_extra;
   logic [3:0] avs_byteenable, exe_wr_idx, exe_rd_idx;
   logic [4:0] avs_address;
   logic [9:0] pul;
   logic [15:0] exe_wr_data, exe_rd_data, stack_pointer, frame_size, frame_restore, flags_wmask;
   logic [15:0] flags_wdata, cpu_flags_reg, loop_begin_in, loop_finish_in, loop_count_in;
   logic [15:0] exc_stack_word, data_ea, table_ea, vis_rdata, rnd, sp0;
   logic [15:0] sv [0:3];
   logic [22:0] pc_load_value, program_counter, pcv;
   logic [23:0] prog_word, prog_addr;
   logic [31:0] avs_writedata, avs_readdata, rd;
   logic [39:0] acc_wdata, accum_a, accum_b, acc;
   int bad_count, checks_done, i, n;

   // One-edge strobes of the execution side share a vector
   assign {pc_load, pc_step, exc_entry, loop_exit, loop_enter, frame_unlink_op, frame_link_op,
      sp_push, shadow_pop, shadow_push} = pul;
   crpv_core_regs u_crpv_core_regs (.*);
   crpv_prog_mem u_crpv_prog_mem (.*);

   // 40 MHz core clock
   initial
   begin
      clock = 1'h0;
      forever #12.5 clock = ~clock;
   end

   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   // Stall cycles a redirected access should cost
   function automatic logic [1:0] xtra(input logic rep, input logic edg, input logic shrt);
      return rep ? (edg ? 2'h2 : 2'h0) : (shrt ? 2'h1 : 2'h2);
   endfunction

   task check(input logic [39:0] seen, input logic [39:0] want);
      checks_done++;
      if (seen !== want)
      begin
         bad_count++;
         $display("wrong value at %0t: saw %h want %h", $time, seen, want);
      end
   endtask

   // Avalon access, held until waitrequest is seen low at an edge
   task bus(input logic wr, input logic [4:0] a, input logic [1:0] be, input logic [15:0] d);
      @(posedge clock);
      avs_address <= a;
      avs_byteenable <= {2'h0, be};
      avs_writedata <= {16'h0000, d};
      avs_write <= wr;
      avs_read <= !wr;
      @(posedge clock);
      for (n = 0; n < 50 && avs_waitrequest !== 1'h0; n++)
         @(posedge clock);
      check(avs_waitrequest, 1'h0);
      rd = avs_readdata;
      avs_write <= 1'h0;
      avs_read <= 1'h0;
   endtask

   task rdchk(input logic [4:0] a, input logic [15:0] want);
      bus(1'h0, a, 2'h3, 16'h0000);
      check(rd, {24'h0, want});
   endtask

   // Strobe for one edge, then one more edge so the result has landed
   task pulse(input logic [9:0] p);
      pul <= p;
      @(posedge clock);
      pul <= 10'h000;
      @(posedge clock);
   endtask

   task conclude;
      if (bad_count == 0 && checks_done > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // Watchdog, well beyond the whole sequence
   initial
   begin
      repeat (20000) @(posedge clock);
      bad_count++;
      conclude;
   end

   // Main sequence
   initial
   begin
      {resetn, avs_read, avs_write, exe_wr_en, exe_wr_byte, sp_pop, data_ea_valid, table_active,
         insn_short_vis, in_repeat, repeat_edge, pul, acc_we, avs_byteenable, exe_wr_idx,
         exe_rd_idx, avs_address, exe_wr_data, frame_size, frame_restore, flags_wmask,
         flags_wdata, loop_begin_in, loop_finish_in, loop_count_in, data_ea, table_ea,
         pc_load_value, avs_writedata, acc_wdata} = '0;
      rnd = 16'h91C5;
      repeat (16) @(posedge clock);
      resetn <= 1'h1;
      rdchk(5'h0F, 16'h0800);
      rdchk(5'h16, 16'h0000);
      // Odd pointer values land aligned; push and frame link move it
      for (i = 0; i < 4; i++)
      begin
         rnd = lfsr(rnd);
         bus(1'h1, 5'h0F, 2'h3, rnd | 16'h0001);
         rdchk(5'h0F, rnd & 16'hFFFE);
      end
      sp0 = (rnd & 16'hFFFE) + 16'h0002;
      pulse(10'h004);
      check(stack_pointer, sp0);
      exe_rd_idx <= 4'hF;
      pulse(10'h000);
      check(exe_rd_data, sp0);
      frame_size <= 16'h0010;
      pulse(10'h008);
      check(stack_pointer, 16'(sp0 + 16'h0010));
      rdchk(5'h0E, sp0);
      // Unlink puts the frame back, then one pop steps down
      frame_restore <= 16'h1234;
      pulse(10'h010);
      check(stack_pointer, sp0);
      rdchk(5'h0E, 16'h1234);
      sp_pop <= 1'h1;
      @(posedge clock);
      sp_pop <= 1'h0;
      @(posedge clock);
      check(stack_pointer, 16'(sp0 - 16'h0002));
      // Core byte write keeps the high byte; bus lanes reach it
      exe_wr_idx <= 4'h5;
      exe_wr_data <= rnd;
      exe_wr_en <= 1'h1;
      @(posedge clock);
      exe_wr_data <= 16'h00C3;
      exe_wr_byte <= 1'h1;
      @(posedge clock);
      exe_wr_en <= 1'h0;
      rdchk(5'h05, {rnd[15:8], 8'hC3});
      bus(1'h1, 5'h05, 2'h2, 16'h7E00);
      rdchk(5'h05, 16'h7EC3);
      // Shadow save and restore of four registers and five flags
      flags_wmask <= 16'hFFFF;
      flags_wdata <= 16'h03FF;
      for (i = 0; i < 4; i++)
      begin
         rnd = lfsr(rnd);
         sv[i] = rnd;
         bus(1'h1, i[4:0], 2'h3, rnd);
      end
      flags_wmask <= 16'h0000;
      pulse(10'h001);
      flags_wmask <= 16'hFFFF;
      flags_wdata <= 16'h0000;
      for (i = 0; i < 4; i++)
         bus(1'h1, i[4:0], 2'h3, ~sv[i]);
      flags_wmask <= 16'h0000;
      rdchk(5'h00, ~sv[0]);
      pulse(10'h002);
      for (i = 0; i < 4; i++)
         rdchk(i[4:0], sv[i]);
      check(cpu_flags_reg, 16'h010F);
      // Loop registers pushed on entry, popped on exit
      for (i = 0; i < 3; i++)
         bus(1'h1, 5'h1A + i[4:0], 2'h3, sv[i]);
      loop_begin_in <= ~sv[0];
      loop_finish_in <= ~sv[1];
      loop_count_in <= ~sv[2];
      pulse(10'h020);
      for (i = 0; i < 3; i++)
         rdchk(5'h1A + i[4:0], ~sv[i]);
      pulse(10'h040);
      for (i = 0; i < 3; i++)
         rdchk(5'h1A + i[4:0], sv[i]);
      // Accumulator loads whole and reads back as three words
      acc = {rnd[7:0], sv[1], sv[2]};
      acc_wdata <= acc;
      acc_we <= 2'h2;
      pulse(10'h000);
      acc_we <= 2'h0;
      check(accum_b, acc);
      for (i = 0; i < 3; i++)
         rdchk(5'h13 + i[4:0], 16'(acc >> (16 * i)));
      // Counter load and step, then exception stacking
      pcv = {1'h0, sv[3][5:0], sv[0][15:1], 1'h0};
      pc_load_value <= pcv;
      pulse(10'h200);
      pulse(10'h100);
      check(program_counter, pcv + 23'h000002);
      sp0 = stack_pointer;
      pulse(10'h080);
      check(exc_stack_word, {8'h0F, 1'h0, program_counter[22:16]});
      check(stack_pointer, 16'(sp0 + 16'h0002));
      // Redirect over all stall cases, then suspended, then switched off
      bus(1'h1, 5'h17, 2'h3, 16'h0004);
      bus(1'h1, 5'h19, 2'h3, {8'h00, sv[3][7:0]});
      bus(1'h1, 5'h18, 2'h3, 16'h0080);
      data_ea_valid <= 1'h1;
      for (i = 0; i < 8; i++)
      begin
         rnd = lfsr(rnd);
         data_ea <= rnd | 16'h8000;
         {insn_short_vis, repeat_edge, in_repeat} <= i[2:0];
         pulse(10'h000);
         check(prog_addr, {1'h0, sv[3][7:0], rnd[14:0]});
         check(vis_extra, xtra(i[0], i[1], i[2]));
      end
      table_ea <= rnd;
      table_active <= 1'h1;
      pulse(10'h000);
      check({vis_hit, prog_addr}, {1'h0, 8'h80, rnd});
      table_active <= 1'h0;
      bus(1'h1, 5'h17, 2'h3, 16'h0000);
      pulse(10'h000);
      check({vis_hit, prog_addr}, {2'h0, program_counter});
      conclude;
   end
endmodule // crpv_core_regs_test
